// ==== design/sdrc_defs.vh ====
// Constants for the sinc decimation rate control block.
// Assumes inclusion by the block's single design file.
`ifndef SDRC_DEFS_VH
`define SDRC_DEFS_VH
// ==============================================
// Register byte offsets
`define SDRC_OFS_MODE 4'h0
`define SDRC_OFS_CHAN 4'h4
`define SDRC_OFS_DATA 4'h8
`define SDRC_OFS_STAT 4'hC
// ==============================================
// Mode register fields
`define SDRC_FS_MSB 9
`define SDRC_BIT_ZL 11
`define SDRC_BIT_REJ 13
`define SDRC_BIT_ORD3 15
`define SDRC_BIT_SEQ 16
// ==============================================
// Channel register fields
`define SDRC_CH_MSB 3
`define SDRC_LAST_LSB 8
`define SDRC_LAST_MSB 11
// ==============================================
// Reset values
`define SDRC_FS_RST 10'h060
`define SDRC_CH_RST 4'h0
// ==============================================
// Rate structure: 1024 master clocks = 16 x 64
`define SDRC_MOD_DIV 5'h10
`define SDRC_DEC_PER_FS 16'h0040
`define SDRC_ORDER4 3'h4
`define SDRC_ORDER3 3'h3
`endif

// ==== design/sdrc_top.v ====
// Third_order_select/sinc4 decimator with rate, settling and channel control.
// Assumes an Avalon-MM master, a modulator bitstream synchronous
// to I_CLK_SYS, and I_CLK_SYS serving as the master clock.
//
// Overview of operation
// R01: Selectable sinc order, zero latency, notch option
// R02: Resets to fourth order, notch off
// R03: One result per 1024 x divider clocks
// R04: Divider word accepts 1 to 1023
// R05: Fourth order settles in four periods
// R06: Channel change resets, first result after settling
// R07: Step leaves cadence unchanged without zero latency
// R08: Mode bit 11 enables zero latency
// R09: Zero latency period is order x 1024 x divider
// R10: Sequencer enabled forces zero latency
// R11: Zero latency restarts filter every result
// R12: Divider 96 gives 50 or 12.5 Hz
// R13: Divider 80 gives 60 or 15 Hz
// R14: Divider 480 gives 10 or 2.5 Hz
// R15: Extra notch keeps output rate unchanged
// R16: Mode bit selects third order filter
// R17: Third order settles in three periods
// R18: Fourth order corner from sinc4 structure
// R19: Third order corner from third_order_select structure
// R20: One-cycle valid strobe with each result
`timescale 1ns/1ns
`default_nettype none
`include "sdrc_defs.vh"

module sdrc_top #(
  parameter ACC_W = 64,
  parameter RES_W = 24
) (
  // Clock and reset
  input wire I_CLK_SYS,
  input wire I_RST,
  // Avalon-MM slave
  input wire [3:0] I_AVS_ADDRESS,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [31:0] I_AVS_WRITEDATA,
  input wire [3:0] I_AVS_BYTEENABLE,
  output reg [31:0] O_AVS_READDATA,
  output reg O_AVS_WAITREQUEST,
  // Modulator side
  input wire I_MOD_BIT,
  output reg O_MOD_SAMPLE,
  output reg O_MOD_RESET,
  output reg [3:0] O_CHANNEL,
  // Result side
  output reg [RES_W-1:0] O_RESULT,
  output reg O_RESULT_VALID
);

  // ==============================================
  // Functions
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer b;
    begin
      be_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          be_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  // ==============================================
  // Control registers
  reg [9:0] fs_r;
  reg zl_r;
  reg rej_r;
  reg ord3_r;
  reg seq_r;
  reg [3:0] chan_r;
  reg [3:0] last_r;
  reg [RES_W-1:0] data_r;
  reg ready_r;

  // ==============================================
  // Filter state
  reg [4:0] mclk_cnt_r;
  reg [15:0] samp_cnt_r;
  reg [2:0] conv_cnt_r;
  reg [ACC_W-1:0] integ_r [0:3];
  reg [ACC_W-1:0] comb_d_r [0:3];
  reg [RES_W-1:0] prev_r;
  integer k;

  // ==============================================
  // Bus decode
  wire bus_req = I_AVS_READ | I_AVS_WRITE;
  wire bus_go = bus_req & ~O_AVS_WAITREQUEST;
  wire do_wr = bus_go & I_AVS_WRITE;
  wire do_rd = bus_go & I_AVS_READ;
  wire wr_mode = do_wr & (I_AVS_ADDRESS == `SDRC_OFS_MODE);
  wire wr_chan = do_wr & (I_AVS_ADDRESS == `SDRC_OFS_CHAN);
  wire rd_data = do_rd & (I_AVS_ADDRESS == `SDRC_OFS_DATA);

  wire [31:0] mode_rd;
  wire [31:0] chan_rd;
  wire [31:0] stat_rd;
  assign mode_rd = {15'h0000, seq_r, ord3_r, 1'b0, rej_r, 1'b0,
                    zl_r, 1'b0, fs_r};
  assign chan_rd = {20'h00000, last_r, 4'h0, chan_r};
  assign stat_rd = {24'h000000, conv_cnt_r, chan_r, ready_r};

  wire [31:0] mode_new = be_merge(mode_rd, I_AVS_WRITEDATA,
                                  I_AVS_BYTEENABLE);
  wire [31:0] chan_new = be_merge(chan_rd, I_AVS_WRITEDATA,
                                  I_AVS_BYTEENABLE);

  // ==============================================
  // Rate and settling decode
  wire zl_eff = zl_r | seq_r; // R10
  wire [2:0] order = ord3_r ? `SDRC_ORDER3 : `SDRC_ORDER4; // R01 R16
  wire [15:0] dec_last;
  assign dec_last = fs_r * `SDRC_DEC_PER_FS - 16'h0001; // R03 R12 R13 R14
  wire mod_tick = (mclk_cnt_r == `SDRC_MOD_DIV - 5'h01);
  wire conv_end = mod_tick & (samp_cnt_r == dec_last);
  wire [2:0] conv_inc = conv_cnt_r + 3'h1;
  wire settled = (conv_inc >= order); // R05 R17
  wire emit = conv_end & settled;
  wire seq_step = emit & seq_r;
  wire [3:0] seq_next = (chan_r == last_r) ? 4'h0 : chan_r + 4'h1;
  wire restart = wr_mode | wr_chan | seq_step; // R06
  wire flt_clr = restart | (emit & zl_eff); // R09 R11

  // ==============================================
  // Comb chain
  reg [ACC_W-1:0] cval [0:4];
  reg [ACC_W-1:0] cic_out;
  always @* begin
    cval[0] = ord3_r ? integ_r[2] : integ_r[3];
    for (k = 0; k < 4; k = k + 1) begin
      cval[k+1] = cval[k] - comb_d_r[k];
    end
    cic_out = ord3_r ? cval[3] : cval[4]; // R18 R19
  end

  wire [RES_W-1:0] raw_res = cic_out[ACC_W-1 -: RES_W];
  wire [RES_W:0] avg_sum = {raw_res[RES_W-1], raw_res} +
                           {prev_r[RES_W-1], prev_r};
  wire [RES_W-1:0] res_sel = rej_r ? avg_sum[RES_W:1] : raw_res; // R15
  wire [ACC_W-1:0] in_val = I_MOD_BIT ? {{(ACC_W-1){1'b0}}, 1'b1}
                                      : {ACC_W{1'b1}};

  // ==============================================
  // Avalon slave handshake
  always @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= 32'h00000000;
    end else if (bus_go) begin
      O_AVS_WAITREQUEST <= 1'b1;
    end else if (bus_req) begin
      O_AVS_WAITREQUEST <= 1'b0;
      case (I_AVS_ADDRESS)
        `SDRC_OFS_MODE: O_AVS_READDATA <= mode_rd;
        `SDRC_OFS_CHAN: O_AVS_READDATA <= chan_rd;
        `SDRC_OFS_DATA: O_AVS_READDATA <= {8'h00, data_r};
        `SDRC_OFS_STAT: O_AVS_READDATA <= stat_rd;
        default: O_AVS_READDATA <= 32'h00000000;
      endcase
    end
  end

  // ==============================================
  // Control registers and sequencer
  always @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      fs_r <= `SDRC_FS_RST;
      zl_r <= 1'b0;
      rej_r <= 1'b0;
      ord3_r <= 1'b0; // R02
      seq_r <= 1'b0;
      chan_r <= `SDRC_CH_RST;
      last_r <= `SDRC_CH_RST;
    end else begin
      if (wr_mode) begin
        if (mode_new[`SDRC_FS_MSB:0] != 10'h000) begin
          fs_r <= mode_new[`SDRC_FS_MSB:0]; // R04
        end
        zl_r <= mode_new[`SDRC_BIT_ZL]; // R08
        rej_r <= mode_new[`SDRC_BIT_REJ];
        ord3_r <= mode_new[`SDRC_BIT_ORD3]; // R16
        seq_r <= mode_new[`SDRC_BIT_SEQ];
      end
      if (wr_chan) begin
        chan_r <= chan_new[`SDRC_CH_MSB:0];
        last_r <= chan_new[`SDRC_LAST_MSB:`SDRC_LAST_LSB];
      end else if (seq_step) begin
        chan_r <= seq_next;
      end
    end
  end

  // ==============================================
  // Rate counters and settling
  always @(posedge I_CLK_SYS) begin
    if (I_RST || flt_clr) begin
      mclk_cnt_r <= 5'h00;
      samp_cnt_r <= 16'h0000;
      conv_cnt_r <= 3'h0; // R06
    end else begin
      mclk_cnt_r <= mod_tick ? 5'h00 : mclk_cnt_r + 5'h01;
      if (mod_tick) begin
        samp_cnt_r <= conv_end ? 16'h0000 : samp_cnt_r + 16'h0001;
      end
      if (conv_end && !settled) begin
        conv_cnt_r <= conv_inc;
      end else if (conv_end) begin
        conv_cnt_r <= order; // R07
      end
    end
  end

  // ==============================================
  // Integrators and comb delays
  always @(posedge I_CLK_SYS) begin
    if (I_RST || flt_clr) begin
      for (k = 0; k < 4; k = k + 1) begin
        integ_r[k] <= {ACC_W{1'b0}};
        comb_d_r[k] <= {ACC_W{1'b0}};
      end
    end else if (mod_tick) begin
      integ_r[0] <= integ_r[0] + in_val;
      for (k = 1; k < 4; k = k + 1) begin
        integ_r[k] <= integ_r[k] + integ_r[k-1];
      end
      if (conv_end) begin
        for (k = 0; k < 4; k = k + 1) begin
          comb_d_r[k] <= cval[k];
        end
      end
    end
  end

  // ==============================================
  // Results and strobes
  always @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      data_r <= {RES_W{1'b0}};
      prev_r <= {RES_W{1'b0}};
      ready_r <= 1'b0;
      O_RESULT <= {RES_W{1'b0}};
      O_RESULT_VALID <= 1'b0;
      O_MOD_SAMPLE <= 1'b0;
      O_MOD_RESET <= 1'b0;
      O_CHANNEL <= `SDRC_CH_RST;
    end else begin
      O_RESULT_VALID <= emit; // R20
      O_MOD_SAMPLE <= mod_tick & ~flt_clr;
      O_MOD_RESET <= restart; // R06
      O_CHANNEL <= wr_chan ? chan_new[`SDRC_CH_MSB:0] :
                   (seq_step ? seq_next : chan_r);
      if (restart) begin
        prev_r <= {RES_W{1'b0}};
      end else if (conv_end) begin
        prev_r <= raw_res;
      end
      if (emit) begin
        data_r <= res_sel;
        O_RESULT <= res_sel; // R20
        ready_r <= 1'b1;
      end else if (rd_data) begin
        ready_r <= 1'b0;
      end
    end
  end

endmodule // sdrc_top

`default_nettype wire

// ==== tb/sdrc_props.sv ====
// Port checker for the rate control block.
// Assumes it is bound into sdrc_top.
`timescale 1ns/1ns
`default_nettype none
module sdrc_props #(parameter RES_W = 24) (
  // Watched ports
  input wire logic I_CLK_SYS, I_RST, I_AVS_READ, I_AVS_WRITE,
  input wire logic O_AVS_WAITREQUEST, O_MOD_RESET, O_RESULT_VALID,
  input wire logic [RES_W-1:0] O_RESULT
);
  // ====
  // Counters
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  logic [11:0] since_val_r, since_rst_r;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      since_val_r <= 12'hFFF;
      since_rst_r <= 12'h000;
    end else begin
      since_val_r <= O_RESULT_VALID ? 12'h000 : since_val_r + {11'h000, ~&since_val_r};
      since_rst_r <= O_MOD_RESET ? 12'h000 : since_rst_r + {11'h000, ~&since_rst_r};
    end
  end
  property p_valid_pulse; O_RESULT_VALID |=> !O_RESULT_VALID; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
  property p_res_hold; $changed(O_RESULT) |-> O_RESULT_VALID; endproperty
  a_res_hold: assert property (p_res_hold) else $error("result moved alone");
  property p_cadence; O_RESULT_VALID |-> since_val_r >= 12'd1023; endproperty
  a_cadence: assert property (p_cadence) else $error("results too close");
  property p_settle; O_RESULT_VALID |-> since_rst_r >= 12'd3000; endproperty
  a_settle: assert property (p_settle) else $error("result before settling");
  property p_mrst_pulse; O_MOD_RESET |=> !O_MOD_RESET; endproperty
  a_mrst_pulse: assert property (p_mrst_pulse) else $error("reset pulse too long");
  property p_wait_one; !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low twice");
  property p_wait_ans; (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
  property p_wait_idle; !(I_AVS_READ || I_AVS_WRITE) |=> O_AVS_WAITREQUEST; endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
  c_valid: cover property (O_RESULT_VALID);
  c_mrst: cover property (O_MOD_RESET);
  c_write: cover property (I_AVS_WRITE && !O_AVS_WAITREQUEST);
endmodule // sdrc_props
bind sdrc_top sdrc_props #(.RES_W(RES_W)) sdrc_props_i (.*);
`default_nettype wire

// ==== tb/sdrc_mod_model.sv ====
// Modulator bitstream model.
// Assumes the block's sample and reset pulses.
`timescale 1ns/1ns
`default_nettype none
module sdrc_mod_model (
  // Block side
  input wire logic i_clk, i_rst, i_sample, i_mreset,
  output logic o_bit
);
  // ====
  // Pattern
  logic [2:0] ph_r;
  always_ff @(posedge i_clk) begin
    if (i_rst || i_mreset) ph_r <= 3'h0;
    else if (i_sample) ph_r <= ph_r + 3'h1;
  end
  assign o_bit = ph_r[2] ^ ph_r[0];
endmodule // sdrc_mod_model
`default_nettype wire

// ==== tb/sdrc_top_tb.sv ====
// Testbench for the rate control block.
// Assumes a 25 MHz clock and the modulator model.
`timescale 1ns/1ns
`default_nettype none
module sdrc_top_tb;
  // ====
  // Bench
  logic clk, rst, rd, wr, mbit, wreq, msmp, mrst, vld;
  logic [3:0] adr, chn;
  logic [31:0] wdat, rdat, d;
  logic [23:0] res;
  int n_errors = 0;
  int tests_run = 0;
  sdrc_top sdrc_top_i (.I_CLK_SYS(clk), .I_RST(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wreq), .I_MOD_BIT(mbit), .O_MOD_SAMPLE(msmp), .O_MOD_RESET(mrst),
    .O_CHANNEL(chn), .O_RESULT(res), .O_RESULT_VALID(vld));
  sdrc_mod_model sdrc_mod_model_i (.i_clk(clk), .i_rst(rst), .i_sample(msmp),
    .i_mreset(mrst), .o_bit(mbit));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task report_and_stop;
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input bit w, input [3:0] a, input [31:0] v, output [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= v;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100) n_errors++;
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rate(input [3:0] a, input [31:0] v, input int s, input int per);
    int c;
    bus(1'b1, a, v, d);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (vld !== 1'b1 && c < 20000);
    chk("settle", 32'h00000001, {31'h0, (c > s - 6 && c < s + 6)});
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (vld !== 1'b1 && c < 20000);
    chk("period", per, c);
  endtask
  task t_defaults;
    bus(1'b0, 4'h0, 32'h00000000, d);
    chk("mode", 32'h00000060, d);
    bus(1'b0, 4'h2, 32'h00000000, d);
    chk("unmapped", 32'h00000000, d);
    bus(1'b1, 4'h0, 32'h00000000, d);
    bus(1'b0, 4'h0, 32'h00000000, d);
    chk("fs_zero_kept", 32'h00000060, d);
  endtask
  task t_rates;
    rate(4'h0, 32'h00000001, 4096, 1024);
    rate(4'h0, 32'h00000801, 4096, 4096);
    rate(4'h0, 32'h00008001, 3072, 1024);
    rate(4'h0, 32'h00008801, 3072, 3072);
    rate(4'h0, 32'h00002001, 4096, 1024);
    rate(4'h0, 32'h00010001, 4096, 4096);
    rate(4'h0, 32'h00000002, 8192, 2048);
  endtask
  task t_chan;
    rate(4'h4, 32'h00000003, 8192, 2048);
    chk("channel", 32'h00000003, {28'h0, chn});
    bus(1'b0, 4'hC, 32'h00000000, d);
    chk("stat_ready", 32'h00000007, {24'h0, d[7:5], d[4:1], d[0]} & 32'h0000001F);
    bus(1'b0, 4'h8, 32'h00000000, d);
    chk("data", {8'h00, res}, d);
    bus(1'b0, 4'hC, 32'h00000000, d);
    chk("stat_clear", 32'h00000006, d & 32'h0000001F);
  endtask
  initial begin
    rst = 1;
    rd = 0;
    wr = 0;
    adr = 0;
    wdat = 0;
    repeat (12) @(posedge clk);
    rst <= 0;
    t_defaults;
    t_rates;
    t_chan;
    report_and_stop;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
endmodule // sdrc_top_tb
`default_nettype wire
